// *** logic/rfmt_regs.sv ***
// Mode, trigger, identification and alias registers of the RFFE slave
`timescale 1ns/1ps
`default_nettype none
module rfmt_regs
  import rfmt_pkg::*;
#(
  parameter logic [6:0] PROD_ID_HI = 7'h15,  // Arbitrary value
  parameter logic       SILICON_VER = 1'b0,  // Arbitrary value
  parameter logic [7:0] MAKER_LO    = 8'h5a, // Arbitrary value
  parameter logic [1:0] MAKER_HI    = 2'h2   // Arbitrary value
) (
  // Reference clock domain
  input  wire logic            ref_clk,
  input  wire logic            rst,
  // Decoded frames from the link front end
  input  wire logic            rffe_clk,
  input  wire logic            wr_stb,
  input  wire logic            rd_stb,
  input  wire rfmt_req_t       req,
  input  wire logic [3:0]      usid0,
  input  wire logic [3:0]      usid1,
  input  wire logic [6:0]      err_set,
  // Channel writes and routes, link domain
  input  wire logic [3:0]      dac_wr,
  input  wire logic [3:0][1:0] dac_route,
  // Read answer
  output logic [7:0]           rdata_ff,
  output logic                 rd_ack_ff,
  // Link domain state
  output var rfmt_pm_t         pm_ff,
  output logic [2:0]           mask_ff,
  output logic [3:0]           usid2_ff,
  output logic [3:0]           group_slave_identifier_ff,
  output logic [6:0]           err_ff,
  output logic [3:0]           pend_ff,
  output logic                 swr_pulse_ff,
  // Reference domain controls
  output var rfmt_pwr_t        pwr_ff,
  output logic [3:0]           dac_load_ff
);
  logic [1:0] rst_sync_ff;
  logic       link_rst, is_bc, is_ind, is_grp, hit_pm, startup;
  logic       swr_req, group_slave_identifier_wr, unique_slave_identifier_wr, rd_ok, rd_map;
  logic [2:0] indiv, nxt_mask, fire;
  logic [7:0] rd_val;
  logic [3:0] rmask, rfire, load_now, busy, ready;
  logic [3:0] req_tgl_ff, due_ff, busy_q_ff, ack_s1_ff, ack_s2_ff;
  logic [1:0] pm_s1_ff, pm_s2_ff, pm_s3_ff;
  logic [3:0] rq_s1_ff, rq_s2_ff, rq_s3_ff;

  // Power-on reset carried into the link domain; the link clock must run
  always_ff @(posedge rffe_clk) begin
    rst_sync_ff <= {rst_sync_ff[0], rst};
  end
  assign link_rst = rst_sync_ff[1];

  // Classify the slave address of the frame
  assign is_bc    = (req.sa == SA_BCAST);
  assign indiv[0] = !is_bc && (req.sa == usid0);
  assign indiv[1] = !is_bc && (req.sa == usid1);
  assign indiv[2] = !is_bc && (req.sa == usid2_ff);
  assign is_ind   = |indiv;
  assign is_grp   = !is_bc && !is_ind && (req.sa == group_slave_identifier_ff);

  assign hit_pm = wr_stb && (req.addr == ADDR_PM)
                  && (is_bc || is_ind || is_grp);

  always_comb begin
    nxt_mask = mask_ff;
    fire     = '0;
    for (int k = 0; k < NUM_ID; k++) begin
      if (hit_pm && indiv[k]) begin
        nxt_mask[k] = req.wdata[MASK_LSB+k];
      end
      // Individual frames use the incoming mask, broadcasts the old one
      fire[k] = hit_pm && req.wdata[k] && (indiv[k] || is_bc || is_grp)
                && !nxt_mask[k];
    end
  end

  // Entering either startup code resets the identifier group
  assign startup = hit_pm && req.wdata[MASK_LSB+3] && !pm_ff[0];

  assign swr_req = wr_stb && req.wdata[SWR_BIT]
                   && (((req.addr == ADDR_STATUS) && (is_ind || is_bc))
                   || ((req.addr == ADDR_SWR) && is_ind));
  assign group_slave_identifier_wr = wr_stb && is_ind
                   && ((req.addr == ADDR_GROUP)
                   || (req.addr == ADDR_GROUP_X));
  assign unique_slave_identifier_wr = wr_stb && (req.addr == ADDR_UNIQUE_SLAVE_IDENTIFIER)
                   && (is_bc || indiv[2])
                   && (req.wdata[7:4] == UNIQUE_SLAVE_IDENTIFIER_HDR);

  always_ff @(posedge rffe_clk) begin
    if (link_rst) begin
      pm_ff   <= PM_ACTIVE;
      mask_ff <= MASK_RST;
    end else if (hit_pm) begin
      pm_ff   <= rfmt_pm_t'(req.wdata[7:6]);
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge rffe_clk) begin
    if (link_rst || startup) begin
      group_slave_identifier_ff <= GROUP_SLAVE_IDENTIFIER_RST;
    end else if (group_slave_identifier_wr) begin
      group_slave_identifier_ff <= req.wdata[3:0];
    end
  end

  always_ff @(posedge rffe_clk) begin
    if (link_rst || startup || swr_req) begin
      usid2_ff <= UNIQUE_SLAVE_IDENTIFIER_RST;
    end else if (unique_slave_identifier_wr) begin
      usid2_ff <= req.wdata[3:0];
    end
  end

  // Soft reset takes effect on the edge that closes the write frame
  always_ff @(posedge rffe_clk) begin
    if (link_rst) begin
      swr_pulse_ff <= 1'b0;
    end else begin
      swr_pulse_ff <= swr_req;
    end
  end

  // Set wins over the read clear so no event is lost
  always_ff @(posedge rffe_clk) begin
    if (link_rst || startup || swr_req) begin
      err_ff <= ERR_RST;
    end else if (rd_ok && ((req.addr == ADDR_STATUS)
                 || (req.addr == ADDR_ERR))) begin
      err_ff <= err_set;
    end else begin
      err_ff <= err_ff | err_set;
    end
  end

  // Read path; group and broadcast reads get no answer
  assign rd_ok = rd_stb && is_ind;
  always_comb begin
    rd_map = 1'b1;
    rd_val = '0;
    unique case (req.addr)
      ADDR_STATUS:  rd_val = {1'b0, err_ff};
      ADDR_ERR:     rd_val = {1'b0, err_ff};
      ADDR_GROUP:   rd_val = {4'h0, group_slave_identifier_ff};
      ADDR_GROUP_X: rd_val = {4'h0, group_slave_identifier_ff};
      ADDR_PM:      rd_val = {pm_ff, mask_ff, pend_ff[2] | pend_ff[3],
                              pend_ff[1], pend_ff[0]};
      ADDR_PROD:    rd_val = {PROD_ID_HI, SILICON_VER};
      ADDR_MAKER:   rd_val = MAKER_LO;
      ADDR_UNIQUE_SLAVE_IDENTIFIER:    rd_val = {2'h0, MAKER_HI, usid2_ff};
      ADDR_SWR:     rd_val = '0;
      ADDR_TEST:    rd_val = TEST_PATTERN;
      default:      rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge rffe_clk) begin
    if (link_rst) begin
      rd_ack_ff <= 1'b0;
      rdata_ff  <= '0;
    end else begin
      rd_ack_ff <= rd_ok && rd_map;
      rdata_ff  <= (rd_ok && rd_map) ? rd_val : '0;
    end
  end

  // Per channel: route lookup, load request and pending status
  always_comb begin
    rmask = '1;
    rfire = '0;
    for (int i = 0; i < NUM_DAC; i++) begin
      if (dac_route[i] != ROUTE_NONE) begin
        rmask[i] = nxt_mask[dac_route[i]];
        rfire[i] = fire[dac_route[i]];
      end
    end
  end
  assign load_now = (dac_wr & rmask) | (rfire & pend_ff);
  assign busy     = req_tgl_ff ^ ack_s2_ff;
  assign ready    = due_ff & ~busy;

  // One load in flight per channel; a later request waits in due_ff
  always_ff @(posedge rffe_clk) begin
    if (link_rst) begin
      req_tgl_ff <= '0;
      due_ff     <= '0;
      busy_q_ff  <= '0;
      ack_s1_ff  <= '0;
      ack_s2_ff  <= '0;
    end else begin
      req_tgl_ff <= req_tgl_ff ^ ready;
      due_ff     <= (due_ff & ~ready) | load_now;
      busy_q_ff  <= busy;
      ack_s1_ff  <= rq_s3_ff;
      ack_s2_ff  <= ack_s1_ff;
    end
  end

  always_ff @(posedge rffe_clk) begin
    if (link_rst) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= dac_wr | (pend_ff & ~(busy_q_ff & ~busy & ~due_ff
                 & ~load_now));
    end
  end

  // Reference domain: mode decode and channel load pulses
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pm_s1_ff <= PM_ACTIVE;
      pm_s2_ff <= PM_ACTIVE;
      pm_s3_ff <= PM_ACTIVE;
      rq_s1_ff <= '0;
      rq_s2_ff <= '0;
      rq_s3_ff <= '0;
    end else begin
      pm_s1_ff <= pm_ff;
      pm_s2_ff <= pm_s1_ff;
      pm_s3_ff <= pm_s2_ff;
      rq_s1_ff <= req_tgl_ff;
      rq_s2_ff <= rq_s1_ff;
      rq_s3_ff <= rq_s2_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dac_load_ff <= '0;
    end else begin
      dac_load_ff <= rq_s2_ff ^ rq_s3_ff;
    end
  end

  // Two mode bits may skew in the crossing; act only on a settled code
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_ff <= PWR_RST;
    end else if (pm_s2_ff == pm_s3_ff) begin
      unique case (rfmt_pm_t'(pm_s3_ff))
        PM_ACTIVE:          pwr_ff <= '{1'b1, 1'b1, 1'b0};
        PM_START,
        PM_START_B:         pwr_ff <= '{1'b1, 1'b0, 1'b0};
        PM_LOW:             pwr_ff <= '{1'b0, 1'b0, 1'b1};
      endcase
    end
  end

  // Checks, link domain
  sequence s_pm_write;
    hit_pm && !indiv[2];
  endsequence
  sequence s_bad_unique_slave_identifier;
    wr_stb && (req.addr == ADDR_UNIQUE_SLAVE_IDENTIFIER) && (req.wdata[7:4] != UNIQUE_SLAVE_IDENTIFIER_HDR);
  endsequence

  property p_mask_guard;
    @(posedge rffe_clk) disable iff (link_rst)
    s_pm_write |=> $stable(mask_ff[2]);
  endproperty
  a_mask_guard: assert property (p_mask_guard)
    else $error("mask 2 changed by a foreign writer");

  property p_unique_slave_identifier_hdr;
    @(posedge rffe_clk) disable iff (link_rst)
    s_bad_unique_slave_identifier and !swr_req and !startup |=> $stable(usid2_ff);
  endproperty
  a_unique_slave_identifier_hdr: assert property (p_unique_slave_identifier_hdr)
    else $error("identifier taken without header nibble");

  property p_swr_bcast;
    @(posedge rffe_clk) disable iff (link_rst)
    wr_stb && is_bc && (req.addr == ADDR_SWR) |=> !swr_pulse_ff;
  endproperty
  a_swr_bcast: assert property (p_swr_bcast)
    else $error("broadcast soft reset accepted at alias");

  property p_swr_unique_slave_identifier;
    @(posedge rffe_clk) disable iff (link_rst)
    swr_req |=> (usid2_ff == UNIQUE_SLAVE_IDENTIFIER_RST) && (err_ff == ERR_RST);
  endproperty
  a_swr_unique_slave_identifier: assert property (p_swr_unique_slave_identifier)
    else $error("soft reset did not restore identifier and flags");

  property p_err_clear;
    @(posedge rffe_clk) disable iff (link_rst)
    rd_ok && (req.addr == ADDR_ERR) |=> err_ff == $past(err_set);
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error flags not cleared by read");

  property p_fixed_test_pattern;
    @(posedge rffe_clk) disable iff (link_rst)
    rd_ok && (req.addr == ADDR_TEST) |=> rd_ack_ff
      && (rdata_ff == TEST_PATTERN);
  endproperty
  a_fixed_test_pattern: assert property (p_fixed_test_pattern)
    else $error("test pattern wrong");

  property p_grp_read;
    @(posedge rffe_clk) disable iff (link_rst)
    rd_stb && is_grp |=> !rd_ack_ff;
  endproperty
  a_grp_read: assert property (p_grp_read)
    else $error("group read answered");

  property p_group_slave_identifier_alias;
    @(posedge rffe_clk) disable iff (link_rst)
    group_slave_identifier_wr && !startup |=> group_slave_identifier_ff == $past(req.wdata[3:0]);
  endproperty
  a_group_slave_identifier_alias: assert property (p_group_slave_identifier_alias)
    else $error("group identifier write lost");

  property p_immediate;
    @(posedge rffe_clk) disable iff (link_rst)
    dac_wr[0] && rmask[0] && !busy[0] && !due_ff[0]
      |=> due_ff[0] ##1 busy[0];
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("masked channel did not start a load");

  property p_pend_done;
    @(posedge rffe_clk) disable iff (link_rst)
    $fell(busy[0]) && !due_ff[0] && !load_now[0] && !dac_wr[0]
      |=> !pend_ff[0];
  endproperty
  a_pend_done: assert property (p_pend_done)
    else $error("pending status stuck after load");

  // Checks, reference domain
  property p_pm_low;
    @(posedge ref_clk) disable iff (rst)
    (pm_s2_ff == PM_LOW) && (pm_s3_ff == PM_LOW)
      |=> pwr_ff.low_power && !pwr_ff.boost_en && !pwr_ff.vout_en;
  endproperty
  a_pm_low: assert property (p_pm_low)
    else $error("low power mode not applied");

  property p_pm_start;
    @(posedge ref_clk) disable iff (rst)
    (pm_s2_ff == pm_s3_ff) && pm_s3_ff[0]
      |=> pwr_ff.boost_en && !pwr_ff.vout_en;
  endproperty
  a_pm_start: assert property (p_pm_start)
    else $error("startup mode outputs wrong");

  property p_pm_active;
    @(posedge ref_clk) disable iff (rst)
    (pm_s2_ff == PM_ACTIVE) && (pm_s3_ff == PM_ACTIVE)
      |=> pwr_ff.boost_en && pwr_ff.vout_en && !pwr_ff.low_power;
  endproperty
  a_pm_active: assert property (p_pm_active)
    else $error("active mode outputs wrong");
endmodule
`default_nettype wire

// *** logic/rfmt_pkg.sv ***
// Constants, types and field layout for the mode, trigger and id registers
// How it works
// - Mode 00 runs boost and enables all four outputs.
// - Modes 01 and 11 run boost with all four outputs disabled.
// - Mode 10 is low power; only the serial interface stays awake.
// - Unmasked channels load their active value only when their trigger fires.
// - Masked channels, the default, load as soon as a new value arrives.
// - Each mask bit is written only by its own individual identifier.
// - Trigger bit k loads channels routed to identifier k.
// - Masks 5, 4, 3 suppress triggers 2, 1, 0 respectively.
// - Trigger bits accept individual writes from their identifier, group writes or broadcasts.
// - Trigger 2 reads back pending status of channel C or D.
// - Trigger 1 reads channel B pending; trigger 0 reads channel A pending.
// - Product id is read-only, fixed bits plus version bit, never reset.
// - Ten-bit maker id: low byte read-only, top two bits in identifier reg.
// - Third identifier changes by broadcast id zero or by its own id.
// - Third identifier defaults on power-on, soft reset or startup entry.
// - Address 0x22 and 0x1b act on the same group identifier.
// - Bit 7 at 0x23 and at 0x1a both trigger the soft reset.
// - Broadcast writes to the soft reset alias at 0x23 are ignored.
// - Error flags read identically at the status and summary addresses.
// - Test pattern register always reads 0xd2.
// - Group id and aliases reset on power-on or startup, not soft reset.
// - Error flags clear after a status read, soft reset, startup or power-up.
// - Soft reset bit reads zero; reset acts in the frame's last cycle.
// - Group messages write only mode and triggers; group reads are ignored.
`default_nettype none
package rfmt_pkg;
  localparam logic [5:0] ADDR_STATUS   = 6'h1a;
  localparam logic [5:0] ADDR_GROUP    = 6'h1b;
  localparam logic [5:0] ADDR_PM       = 6'h1c;
  localparam logic [5:0] ADDR_PROD     = 6'h1d;
  localparam logic [5:0] ADDR_MAKER    = 6'h1e;
  localparam logic [5:0] ADDR_UNIQUE_SLAVE_IDENTIFIER     = 6'h1f;
  localparam logic [5:0] ADDR_GROUP_X  = 6'h22;
  localparam logic [5:0] ADDR_SWR      = 6'h23;
  localparam logic [5:0] ADDR_ERR      = 6'h24;
  localparam logic [5:0] ADDR_TEST     = 6'h2c;
  localparam logic [7:0] TEST_PATTERN  = 8'hd2;
  localparam logic [3:0] SA_BCAST      = 4'h0;
  localparam logic [3:0] UNIQUE_SLAVE_IDENTIFIER_HDR      = 4'h1;
  localparam logic [3:0] UNIQUE_SLAVE_IDENTIFIER_RST      = 4'h7;
  localparam logic [3:0] GROUP_SLAVE_IDENTIFIER_RST      = 4'h0;
  localparam logic [2:0] MASK_RST      = 3'h7;
  localparam logic [6:0] ERR_RST       = 7'h00;
  localparam int         SWR_BIT       = 7;
  localparam int         MASK_LSB      = 3;
  localparam int         NUM_ID        = 3;
  localparam int         NUM_DAC       = 4;
  localparam logic [1:0] ROUTE_NONE    = 2'h3;
  typedef enum logic [1:0] {
    PM_ACTIVE  = 2'b00,
    PM_START   = 2'b01,
    PM_LOW     = 2'b10,
    PM_START_B = 2'b11
  } rfmt_pm_t;
  typedef struct packed {
    logic [3:0] sa;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rfmt_req_t;
  typedef struct packed {
    logic boost_en;
    logic vout_en;
    logic low_power;
  } rfmt_pwr_t;
  localparam rfmt_pwr_t PWR_RST = '{boost_en: 1'b0, vout_en: 1'b0,
                                    low_power: 1'b0};
endpackage
`default_nettype wire

// *** dv/rfmt_master.sv ***
// Bus master model that issues decoded register frames to the bank
`timescale 1ns/1ps
`default_nettype none
module rfmt_master
  import rfmt_pkg::*;
(
  // Link side
  input  wire logic       rffe_clk,
  input  wire logic       rd_ack_ff,
  input  wire logic [7:0] rdata_ff,
  // Frame strobes and request
  output var logic        wr_stb,
  output var logic        rd_stb,
  output var rfmt_req_t   req
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    req    = '0;
  end

  // One frame: request held across the taking edge, answer taken just
  // after that same edge; a released request shows its inverse so stale values
  // can never pass for a live one
  task automatic frame(input logic w, input logic [3:0] s,
                       input logic [5:0] a, input logic [7:0] d,
                       output logic k, output logic [7:0] q);
    @(posedge rffe_clk);
    #1;
    req    = '{sa: s, addr: a, wdata: d};
    wr_stb = w;
    rd_stb = !w;
    @(posedge rffe_clk);
    #1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    req    = ~req;
    k      = rd_ack_ff;
    q      = rdata_ff;
  endtask
endmodule
`default_nettype wire

// *** dv/rfmt_regs_tb.sv ***
// Self-checking bench for the mode, trigger and id register bank
`timescale 1ns/1ps
`default_nettype none
module rfmt_regs_tb;
  import rfmt_pkg::*;
  localparam logic [6:0] P_HI = 7'h2b; // Arbitrary value
  localparam logic       P_V  = 1'b1;  // Arbitrary value
  localparam logic [7:0] M_LO = 8'h66; // Arbitrary value
  localparam logic [1:0] M_HI = 2'h1;  // Arbitrary value
  localparam logic [3:0] U0   = 4'h3;
  localparam logic [3:0] U1   = 4'h4;
  logic            ref_clk, rffe_clk, rst, wr_stb, rd_stb;
  logic            rd_ack_ff, swr_pulse_ff, ack;
  rfmt_req_t       req;
  logic [6:0]      err_set, err_ff;
  logic [3:0]      dac_wr, usid2_ff, group_slave_identifier_ff, pend_ff, dac_load_ff;
  logic [3:0][1:0] dac_route;
  logic [7:0]      rdata_ff, q;
  rfmt_pm_t        pm_ff;
  logic [2:0]      mask_ff;
  rfmt_pwr_t       pwr_ff;
  logic [2:0]      pexp [4];
  int              error_cnt, samples_checked;

  rfmt_regs #(
    .PROD_ID_HI  (P_HI),
    .SILICON_VER (P_V),
    .MAKER_LO    (M_LO),
    .MAKER_HI    (M_HI)
  ) u_dut (
    .ref_clk, .rst, .rffe_clk, .wr_stb, .rd_stb, .req,
    .usid0 (U0), .usid1 (U1), .err_set, .dac_wr, .dac_route,
    .rdata_ff, .rd_ack_ff, .pm_ff, .mask_ff, .usid2_ff, .group_slave_identifier_ff,
    .err_ff, .pend_ff, .swr_pulse_ff, .pwr_ff, .dac_load_ff
  );
  rfmt_master u_mst (.rffe_clk, .rd_ack_ff, .rdata_ff, .wr_stb, .rd_stb,
                     .req);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Link clock offset so its edges never line up with the reference
  initial begin
    rffe_clk = 1'b0;
    #1.7;
    forever #3 rffe_clk = ~rffe_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    $display("[FAIL] %0t run timed out", $time);
    test_done();
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [5:0] a,
                    input logic [7:0] d);
    logic       k;
    logic [7:0] x;
    u_mst.frame(1'b1, s, a, d, k, x);
  endtask
  task automatic rd(input logic [3:0] s, input logic [5:0] a,
                    input logic [7:0] e);
    u_mst.frame(1'b0, s, a, 8'h00, ack, q);
    chk({7'h0, ack}, 8'h01);
    chk(q, e);
  endtask
  task automatic nak(input logic [3:0] s, input logic [5:0] a);
    u_mst.frame(1'b0, s, a, 8'h00, ack, q);
    chk({7'h0, ack}, 8'h00);
  endtask
  task automatic pulse(input int i);
    @(posedge rffe_clk);
    #1;
    dac_wr[i] = 1'b1;
    @(posedge rffe_clk);
    #1;
    dac_wr = '0;
  endtask
  task automatic flag(input logic [6:0] f);
    @(posedge rffe_clk);
    #1;
    err_set = f;
    @(posedge rffe_clk);
    #1;
    err_set = '0;
  endtask
  // Bounded watch for a channel load; a missing expected load ends the run
  task automatic load(input int i, input logic e);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 30 && !seen; n++) begin
      @(posedge ref_clk);
      #1;
      seen = (dac_load_ff[i] === 1'b1);
    end
    chk({7'h0, seen}, {7'h0, e});
    if (e && !seen) test_done();
    if (e) begin
      repeat (15) @(posedge rffe_clk);
      #1;
      chk({7'h0, pend_ff[i]}, 8'h00);
    end
  endtask
  task automatic pwr(input logic [2:0] e);
    for (int n = 0; n < 20 && pwr_ff !== e; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({5'h0, pwr_ff}, {5'h0, e});
    if (pwr_ff !== e) test_done();
  endtask

  initial begin
    pexp = '{3'b110, 3'b100, 3'b001, 3'b100};
    rst = 1'b1;
    dac_wr = '0;
    err_set = '0;
    dac_route = {2'd2, 2'd2, 2'd1, 2'd0};
    error_cnt = 0;
    samples_checked = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge rffe_clk);
    #1;
    chk({2'b0, pm_ff, 1'b0, mask_ff}, 8'h07);
    rd(U0, ADDR_TEST, TEST_PATTERN);
    wr(U0, ADDR_TEST, 8'h00);
    rd(U0, ADDR_TEST, 8'hd2);
    rd(U0, ADDR_PROD, {P_HI, P_V});
    rd(U1, ADDR_MAKER, M_LO);
    rd(U0, ADDR_UNIQUE_SLAVE_IDENTIFIER, {2'b00, M_HI, 4'h7});
    nak(U0, 6'h30);
    nak(SA_BCAST, ADDR_TEST);
    $display("test ident done");
    wr(SA_BCAST, ADDR_UNIQUE_SLAVE_IDENTIFIER, 8'h1a);
    chk({4'h0, usid2_ff}, 8'h0a);
    wr(4'ha, ADDR_UNIQUE_SLAVE_IDENTIFIER, 8'h25);
    chk({4'h0, usid2_ff}, 8'h0a);
    wr(4'ha, ADDR_UNIQUE_SLAVE_IDENTIFIER, 8'h16);
    rd(4'h6, ADDR_UNIQUE_SLAVE_IDENTIFIER, {2'b00, M_HI, 4'h6});
    wr(U1, ADDR_GROUP_X, 8'hf5);
    rd(U0, ADDR_GROUP, 8'h05);
    wr(4'h5, ADDR_PM, 8'h80);
    chk({6'h0, pm_ff}, 8'h02);
    nak(4'h5, ADDR_TEST);
    wr(SA_BCAST, ADDR_SWR, 8'h80);
    chk({7'h0, swr_pulse_ff}, 8'h00);
    chk({4'h0, usid2_ff}, 8'h06);
    wr(U0, ADDR_SWR, 8'h80);
    chk({7'h0, swr_pulse_ff}, 8'h01);
    chk({4'h0, usid2_ff}, 8'h07);
    chk({4'h0, group_slave_identifier_ff}, 8'h05);
    @(posedge rffe_clk);
    #1;
    chk({7'h0, swr_pulse_ff}, 8'h00);
    rd(U0, ADDR_SWR, 8'h00);
    flag(7'h08);
    rd(U0, ADDR_ERR, 8'h08);
    rd(U0, ADDR_STATUS, 8'h00);
    flag(7'h41);
    rd(U0, ADDR_STATUS, 8'h41);
    rd(U0, ADDR_ERR, 8'h00);
    flag(7'h02);
    chk({1'b0, err_ff}, 8'h02);
    wr(U1, ADDR_STATUS, 8'h80);
    chk({1'b0, err_ff}, 8'h00);
    rd(U0, ADDR_ERR, 8'h00);
    $display("test ids done");
    wr(SA_BCAST, ADDR_PM, 8'h00);
    chk({5'h0, mask_ff}, 8'h07);
    wr(U0, ADDR_PM, 8'h00);
    wr(4'h7, ADDR_PM, 8'h00);
    chk({5'h0, mask_ff}, 8'h02);
    pulse(0);
    rd(U1, ADDR_PM, 8'h11);
    load(0, 1'b0);
    wr(SA_BCAST, ADDR_PM, 8'h01);
    load(0, 1'b1);
    pulse(1);
    load(1, 1'b1);
    pulse(3);
    rd(U0, ADDR_PM, 8'h14);
    wr(4'h7, ADDR_PM, 8'h04);
    load(3, 1'b1);
    dac_route[2] = ROUTE_NONE;
    pulse(2);
    load(2, 1'b1);
    wr(U0, ADDR_PM, 8'h08);
    chk({5'h0, mask_ff}, 8'h03);
    pulse(0);
    load(0, 1'b1);
    $display("test triggers done");
    for (int m = 0; m < 4; m++) begin
      wr(U0, ADDR_PM, {2'(m), 6'h00});
      pwr(pexp[m]);
      if (m == 1) chk({4'h0, group_slave_identifier_ff}, 8'h00);
    end
    $display("test modes done");
    test_done();
  end
endmodule
`default_nettype wire
